/* File: src/uplc_defines.vh */
// constants for the usb port line control block
// assumes inclusion by bare name from the design files
`ifndef UPLC_DEFINES_VH
`define UPLC_DEFINES_VH
`define UPLC_CTRL_ADDR_E1 16'hC08A
`define UPLC_CTRL_ADDR_E2 16'hC0AA
`define UPLC_CNT_ADDR_E1 16'hC084
`define UPLC_CNT_ADDR_E2 16'hC0A4
`define UPLC_B_DP 15
`define UPLC_B_DM 14
`define UPLC_A_DP 13
`define UPLC_A_DM 12
`define UPLC_B_LOW 11
`define UPLC_A_LOW 10
`define UPLC_MODE 9
`define UPLC_B_RES 8
`define UPLC_A_RES 7
`define UPLC_B_FRC_HI 6
`define UPLC_B_FRC_LO 5
`define UPLC_A_FRC_HI 4
`define UPLC_A_FRC_LO 3
`define UPLC_SUSP 2
`define UPLC_B_SOF 1
`define UPLC_A_SOF 0
`define UPLC_PSEL 14
`define UPLC_CTRL_WMASK 16'h0FFF
`define UPLC_CTRL_RST 12'h000
`define UPLC_FRC_NORM 2'h0
`define UPLC_FRC_J 2'h1
`define UPLC_FRC_SE0 2'h2
`define UPLC_FRC_K 2'h3
`endif

/* File: src/uplc_line_port.v */
// one usb port: line sync, resistor and line force decode
// assumes d+/d- levels arrive asynchronously from the pads
`timescale 1ns/1ps
`include "uplc_defines.vh"
module uplc_line_port (
  input wire core_clk,
  input wire rst_n,
  input wire dp_in,
  input wire dm_in,
  input wire host_mode,
  input wire low_speed,
  input wire res_en,
  input wire [1:0] force_sel,
  output reg dp_sync_q,
  output reg dm_sync_q,
  output reg dp_pu_q,
  output reg dm_pu_q,
  output reg dp_pd_q,
  output reg dm_pd_q,
  output reg dp_out_q,
  output reg dm_out_q,
  output reg line_oe_q
);
  reg dp_meta_q;
  reg dm_meta_q;
  reg dp_o_d;
  reg dm_o_d;
  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_meta_q <= 1'b0;
      dm_meta_q <= 1'b0;
      dp_sync_q <= 1'b0;
      dm_sync_q <= 1'b0;
    end else begin
      dp_meta_q <= dp_in;
      dm_meta_q <= dm_in;
      dp_sync_q <= dp_meta_q;
      dm_sync_q <= dm_meta_q;
    end
  end
  // ---------------------------------------------------------------
  // force decode
  // ---------------------------------------------------------------
  // j and k follow the port speed; low speed swaps line polarity
  always @* begin
    dp_o_d = 1'b0;
    dm_o_d = 1'b0;
    case (force_sel)
      `UPLC_FRC_SE0: begin
        dp_o_d = 1'b0;
        dm_o_d = 1'b0;
      end
      `UPLC_FRC_J: begin
        dp_o_d = ~low_speed;
        dm_o_d = low_speed;
      end
      `UPLC_FRC_K: begin
        dp_o_d = low_speed;
        dm_o_d = ~low_speed;
      end
      default: begin
        dp_o_d = 1'b0;
        dm_o_d = 1'b0;
      end
    endcase
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_pu_q <= 1'b0;
      dm_pu_q <= 1'b0;
      dp_pd_q <= 1'b0;
      dm_pd_q <= 1'b0;
      dp_out_q <= 1'b0;
      dm_out_q <= 1'b0;
      line_oe_q <= 1'b0;
    end else begin
      dp_pd_q <= res_en & host_mode;
      dm_pd_q <= res_en & host_mode;
      dp_pu_q <= res_en & ~host_mode & ~low_speed;
      dm_pu_q <= res_en & ~host_mode & low_speed;
      dp_out_q <= dp_o_d;
      dm_out_q <= dm_o_d;
      line_oe_q <= (force_sel != `UPLC_FRC_NORM);
    end
  end
endmodule // uplc_line_port

/* File: src/uplc_top.v */
// usb port line control register for one serial engine
// assumes a 16-bit word register port shared by cpu and host port
// Function
// - read back port b and a line levels
// - speed bits: 1 low, 0 full
// - mode bit: 1 host, 0 device
// - device mode serves only the chosen port; here both ports keep pulls and force, the choice only sets the active outputs
// - resistor enable 0 removes all resistors
// - host mode enables pull-downs both lines
// - device mode single pull-up by speed
// - force field: normal, j, se0, k
// - forcing ignores active port choice
// - suspend powers down transceivers, wakeup detect stays
// - host frame markers: sof full, eop low
// - reachable by cpu and parallel host port
// - port choice: 0 port a, 1 b
`timescale 1ns/1ps
`include "uplc_defines.vh"
module uplc_top #(
  parameter [15:0] CTRL_ADDR = `UPLC_CTRL_ADDR_E1,
  parameter [15:0] CNT_ADDR = `UPLC_CNT_ADDR_E1
) (
  input wire core_clk,
  input wire resetn,
  input wire cpu_sel,
  input wire cpu_wr,
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_wdata,
  output reg [15:0] cpu_rdata_q,
  input wire hpi_sel,
  input wire hpi_wr,
  input wire [15:0] hpi_addr,
  input wire [15:0] hpi_wdata,
  output reg [15:0] hpi_rdata_q,
  input wire port_a_dp_in,
  input wire port_a_dm_in,
  input wire port_b_dp_in,
  input wire port_b_dm_in,
  output wire port_a_dp_out,
  output wire port_a_dm_out,
  output wire port_a_oe,
  output wire port_b_dp_out,
  output wire port_b_dm_out,
  output wire port_b_oe,
  output wire port_a_dp_pu,
  output wire port_a_dm_pu,
  output wire port_a_dp_pd,
  output wire port_a_dm_pd,
  output wire port_b_dp_pu,
  output wire port_b_dm_pu,
  output wire port_b_dp_pd,
  output wire port_b_dm_pd,
  output reg xcvr_suspend_q,
  output reg wake_detect_en_q,
  output reg port_a_active_q,
  output reg port_b_active_q,
  output reg host_mode_q,
  output reg port_a_sof_q,
  output reg port_a_eop_q,
  output reg port_b_sof_q,
  output reg port_b_eop_q
);
  reg rst_meta_q;
  reg rst_sync_q;
  reg [11:0] ctrl_q;
  reg port_sel_q;
  wire [1:0] dp_sync;
  wire [1:0] dm_sync;
  wire [1:0] line_in_dp;
  wire [1:0] line_in_dm;
  wire [1:0] low_spd;
  wire [1:0] res_en;
  wire [3:0] frc;
  wire [1:0] dp_pu;
  wire [1:0] dm_pu;
  wire [1:0] dp_pd;
  wire [1:0] dm_pd;
  wire [1:0] dp_o;
  wire [1:0] dm_o;
  wire [1:0] oe;
  wire [15:0] ctrl_view;
  wire cpu_ctl_wr;
  wire hpi_ctl_wr;
  wire cpu_cnt_wr;
  wire hpi_cnt_wr;
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign cpu_ctl_wr = cpu_sel & cpu_wr & (cpu_addr == CTRL_ADDR);
  assign hpi_ctl_wr = hpi_sel & hpi_wr & (hpi_addr == CTRL_ADDR);
  assign cpu_cnt_wr = cpu_sel & cpu_wr & (cpu_addr == CNT_ADDR);
  assign hpi_cnt_wr = hpi_sel & hpi_wr & (hpi_addr == CNT_ADDR);
  // host port wins a same-cycle collision; the cpu write is dropped
  always @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= `UPLC_CTRL_RST;
      port_sel_q <= 1'b0;
    end else begin
      if (hpi_ctl_wr) begin
        ctrl_q <= hpi_wdata[11:0];
      end else if (cpu_ctl_wr) begin
        ctrl_q <= cpu_wdata[11:0];
      end
      if (hpi_cnt_wr) begin
        port_sel_q <= hpi_wdata[`UPLC_PSEL];
      end else if (cpu_cnt_wr) begin
        port_sel_q <= cpu_wdata[`UPLC_PSEL];
      end
    end
  end
  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  assign ctrl_view = {dp_sync[1], dm_sync[1], dp_sync[0], dm_sync[0],
                      ctrl_q};
  always @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cpu_rdata_q <= 16'h0000;
      hpi_rdata_q <= 16'h0000;
    end else begin
      // only the port choice bit of the count register lives here
      cpu_rdata_q <= (cpu_addr == CTRL_ADDR) ? ctrl_view :
                     (cpu_addr == CNT_ADDR) ?
                     {1'b0, port_sel_q, 14'h0000} : 16'h0000;
      hpi_rdata_q <= (hpi_addr == CTRL_ADDR) ? ctrl_view :
                     (hpi_addr == CNT_ADDR) ?
                     {1'b0, port_sel_q, 14'h0000} : 16'h0000;
    end
  end
  // ---------------------------------------------------------------
  // ports
  // ---------------------------------------------------------------
  assign line_in_dp = {port_b_dp_in, port_a_dp_in};
  assign line_in_dm = {port_b_dm_in, port_a_dm_in};
  assign low_spd = {ctrl_q[`UPLC_B_LOW], ctrl_q[`UPLC_A_LOW]};
  assign res_en = {ctrl_q[`UPLC_B_RES], ctrl_q[`UPLC_A_RES]};
  assign frc = {ctrl_q[`UPLC_B_FRC_HI:`UPLC_B_FRC_LO],
                ctrl_q[`UPLC_A_FRC_HI:`UPLC_A_FRC_LO]};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      // force acts regardless of the active port
      uplc_line_port u_port (
        .core_clk(core_clk),
        .rst_n(rst_sync_q),
        .dp_in(line_in_dp[gi]),
        .dm_in(line_in_dm[gi]),
        .host_mode(ctrl_q[`UPLC_MODE]),
        .low_speed(low_spd[gi]),
        .res_en(res_en[gi]),
        .force_sel(frc[2*gi+1:2*gi]),
        .dp_sync_q(dp_sync[gi]),
        .dm_sync_q(dm_sync[gi]),
        .dp_pu_q(dp_pu[gi]),
        .dm_pu_q(dm_pu[gi]),
        .dp_pd_q(dp_pd[gi]),
        .dm_pd_q(dm_pd[gi]),
        .dp_out_q(dp_o[gi]),
        .dm_out_q(dm_o[gi]),
        .line_oe_q(oe[gi])
      );
    end
  endgenerate
  assign port_a_dp_out = dp_o[0];
  assign port_a_dm_out = dm_o[0];
  assign port_a_oe = oe[0];
  assign port_b_dp_out = dp_o[1];
  assign port_b_dm_out = dm_o[1];
  assign port_b_oe = oe[1];
  assign port_a_dp_pu = dp_pu[0];
  assign port_a_dm_pu = dm_pu[0];
  assign port_a_dp_pd = dp_pd[0];
  assign port_a_dm_pd = dm_pd[0];
  assign port_b_dp_pu = dp_pu[1];
  assign port_b_dm_pu = dm_pu[1];
  assign port_b_dp_pd = dp_pd[1];
  assign port_b_dm_pd = dm_pd[1];
  // ---------------------------------------------------------------
  // engine mode, suspend, frame markers
  // ---------------------------------------------------------------
  // marker enables are also gated by host mode in case software
  // leaves them set in device mode
  always @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      xcvr_suspend_q <= 1'b0;
      wake_detect_en_q <= 1'b0;
      port_a_active_q <= 1'b0;
      port_b_active_q <= 1'b0;
      host_mode_q <= 1'b0;
      port_a_sof_q <= 1'b0;
      port_a_eop_q <= 1'b0;
      port_b_sof_q <= 1'b0;
      port_b_eop_q <= 1'b0;
    end else begin
      host_mode_q <= ctrl_q[`UPLC_MODE];
      xcvr_suspend_q <= ctrl_q[`UPLC_SUSP];
      wake_detect_en_q <= ctrl_q[`UPLC_SUSP];
      port_a_active_q <= ~port_sel_q;
      port_b_active_q <= port_sel_q;
      port_a_sof_q <= ctrl_q[`UPLC_MODE] & ctrl_q[`UPLC_A_SOF] &
                      ~port_sel_q & ~low_spd[0];
      port_a_eop_q <= ctrl_q[`UPLC_MODE] & ctrl_q[`UPLC_A_SOF] &
                      ~port_sel_q & low_spd[0];
      port_b_sof_q <= ctrl_q[`UPLC_MODE] & ctrl_q[`UPLC_B_SOF] &
                      port_sel_q & ~low_spd[1];
      port_b_eop_q <= ctrl_q[`UPLC_MODE] & ctrl_q[`UPLC_B_SOF] &
                      port_sel_q & low_spd[1];
    end
  end
endmodule // uplc_top

/* File: verif/tb_uplc_top.sv */
// bench for one line control engine at its default addresses
// assumes the peer model on both ports and the bound checker
`timescale 1ns/1ps
`include "uplc_defines.vh"
module tb_uplc_top;
  localparam [15:0] CA = `UPLC_CTRL_ADDR_E1;
  localparam [15:0] NA = `UPLC_CNT_ADDR_E1;
  logic core_clk = 1'b0, resetn = 1'b0, drv_en = 1'b0;
  logic cpu_sel = 1'b0, cpu_wr = 1'b0, hpi_sel = 1'b0, hpi_wr = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic [15:0] hpi_addr = 16'h0000, hpi_wdata = 16'h0000;
  logic [1:0] drv_a = 2'h0, drv_b = 2'h0;
  wire [15:0] cpu_rdata_q, hpi_rdata_q;
  wire port_a_dp_in, port_a_dm_in, port_b_dp_in, port_b_dm_in;
  wire port_a_dp_out, port_a_dm_out, port_a_oe;
  wire port_b_dp_out, port_b_dm_out, port_b_oe;
  wire port_a_dp_pu, port_a_dm_pu, port_a_dp_pd, port_a_dm_pd;
  wire port_b_dp_pu, port_b_dm_pu, port_b_dp_pd, port_b_dm_pd;
  wire xcvr_suspend_q, wake_detect_en_q, port_a_active_q, port_b_active_q;
  wire host_mode_q, port_a_sof_q, port_a_eop_q, port_b_sof_q, port_b_eop_q;
  wire [3:0] pl_a = {port_a_dp_pu, port_a_dm_pu, port_a_dp_pd, port_a_dm_pd};
  wire [3:0] pl_b = {port_b_dp_pu, port_b_dm_pu, port_b_dp_pd, port_b_dm_pd};
  wire [2:0] dr_a = {port_a_oe, port_a_dp_out, port_a_dm_out};
  wire [2:0] dr_b = {port_b_oe, port_b_dp_out, port_b_dm_out};
  wire [5:0] mk = {port_a_active_q, port_b_active_q, port_a_sof_q,
    port_a_eop_q, port_b_sof_q, port_b_eop_q};
  wire [2:0] sm = {xcvr_suspend_q, wake_detect_en_q, host_mode_q};
  int mismatches = 0, n_compared = 0;
  uplc_top i_dut (.*);
  uplc_usb_peer i_pa (.core_clk(core_clk), .drv_en(drv_en), .drv(drv_a),
    .oe(port_a_oe), .out({port_a_dp_out, port_a_dm_out}), .pull(pl_a),
    .line({port_a_dp_in, port_a_dm_in}));
  uplc_usb_peer i_pb (.core_clk(core_clk), .drv_en(drv_en), .drv(drv_b),
    .oe(port_b_oe), .out({port_b_dp_out, port_b_dm_out}), .pull(pl_b),
    .line({port_b_dp_in, port_b_dm_in}));
  // ----
  // shared tasks
  // ----
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access; the waits let a write reach every output
  task automatic acc(bit h, bit w, logic [15:0] a, d, output logic [15:0] r);
    @(negedge core_clk);
    if (h) {hpi_sel, hpi_wr, hpi_addr, hpi_wdata} = {1'b1, w, a, d};
    else {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
    @(negedge core_clk);
    r = h ? hpi_rdata_q : cpu_rdata_q;
    {cpu_sel, hpi_sel} = 2'h0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic wr(bit h, logic [15:0] a, d);
    logic [15:0] r;
    acc(h, 1'b1, a, d, r);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [15:0] r;
    acc(1'b0, 1'b0, CA, 16'h0000, r);
    chk("reset", 16'h0000, {r[11:0], pl_a[1:0], port_a_oe, port_b_oe});
    chk("reset pulls", 16'h0000, {pl_a, pl_b});
    // port choice resets to 0, so port a is the active one
    chk("reset outs", 16'h0100, {mk, sm});
    wr(1'b1, CA, 16'hF2A6);
    acc(1'b0, 1'b0, CA, 16'h0000, r);
    chk("ctrl by cpu", 16'h02A6, r & 16'h0FFF);
    chk("suspend", 16'h0007, sm);
    wr(1'b0, CA, 16'h0000);
    acc(1'b1, 1'b0, CA, 16'h0000, r);
    chk("ctrl by hpi", 16'h0000, (r & 16'h0FFF) | sm);
    wr(1'b0, NA, 16'hFFFF);
    acc(1'b1, 1'b0, NA, 16'h0000, r);
    chk("count", 16'h4000, r);
    // both masters write the control word in one cycle; host port wins
    @(negedge core_clk);
    {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {2'h3, CA, 16'h0004};
    {hpi_sel, hpi_wr, hpi_addr, hpi_wdata} = {2'h3, CA, 16'h0200};
    @(negedge core_clk);
    {cpu_sel, hpi_sel} = 2'h0;
    acc(1'b0, 1'b0, CA, 16'h0000, r);
    chk("clash", 16'h0200, r & 16'h0FFF);
    acc(1'b0, 1'b0, 16'hC08C, 16'h0000, r);
    chk("unmapped", 16'h0000, r);
  endtask
  task automatic t_force;
    logic [15:0] r;
    logic [1:0] e;
    for (int i = 0; i < 8; i++) begin
      wr(1'b0, CA, {4'h0, i[2], i[2], 3'h0, i[1:0], i[1:0], 3'h0});
      // normal and se0 leave both drive levels low
      e = (i[1:0] == 2'h2 || i[1:0] == 2'h0) ? 2'h0 :
        (i[1:0] == 2'h1) ^ i[2] ? 2'h2 : 2'h1;
      repeat (3) @(negedge core_clk);
      acc(1'b0, 1'b0, CA, 16'h0000, r);
      chk("drive a", {i[1:0] != 2'h0, e}, dr_a);
      chk("drive b", {i[1:0] != 2'h0, e}, dr_b);
      if (i[1:0] != 2'h0) chk("forced", {e, e}, r[15:12]);
    end
  endtask
  task automatic t_pulls;
    logic [3:0] e;
    for (int i = 0; i < 8; i++) begin
      wr(1'b0, CA, {4'h0, i[0], i[0], i[1], i[2], i[2], 7'h00});
      e = !i[2] ? 4'h0 : i[1] ? 4'h3 : i[0] ? 4'h4 : 4'h8;
      chk("pulls a", e, pl_a);
      chk("pulls b", e, pl_b);
    end
  endtask
  task automatic t_status;
    logic [15:0] r;
    wr(1'b0, CA, 16'h0000);
    drv_en = 1'b1;
    for (int v = 0; v < 16; v++) begin
      {drv_b, drv_a} = v[3:0];
      repeat (4) @(negedge core_clk);
      acc(1'b0, 1'b0, CA, 16'h0000, r);
      chk("line levels", v[3:0], r[15:12]);
    end
    drv_en = 1'b0;
  endtask
  task automatic t_mark;
    logic [5:0] e;
    for (int i = 0; i < 8; i++) begin
      wr(1'b1, NA, {1'b0, i[2], 14'h0000});
      wr(1'b0, CA, {4'h0, i[1], i[1], i[0], 7'h00, i[0], i[0]});
      repeat (6) @(negedge core_clk);
      e = {!i[2], i[2], i[0] & !i[2] & !i[1], i[0] & !i[2] & i[1],
        i[0] & i[2] & !i[1], i[0] & i[2] & i[1]};
      chk("markers", e, mk);
    end
  endtask
  // ----
  // clock, sequence, watchdog
  // ----
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_regs;
    t_force;
    t_pulls;
    t_status;
    t_mark;
    end_of_test;
  end
  // whole run is well under 1000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_of_test;
  end
endmodule // tb_uplc_top

/* File: verif/uplc_asserts.sv */
// checker: line control register relations seen at the top ports
// assumes bind into uplc_top, addresses handed on from its parameters
`timescale 1ns/1ps
module uplc_asserts #(
  parameter [15:0] CTRL_ADDR = 16'hC08A,
  parameter [15:0] CNT_ADDR = 16'hC084
) (
  input wire core_clk,
  input wire resetn,
  input wire cpu_sel,
  input wire cpu_wr,
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_wdata,
  input wire hpi_sel,
  input wire hpi_wr,
  input wire [15:0] hpi_addr,
  input wire [15:0] hpi_wdata,
  input wire port_a_oe,
  input wire port_b_oe,
  input wire port_a_dp_pu,
  input wire port_a_dm_pu,
  input wire port_a_dp_pd,
  input wire port_a_dm_pd,
  input wire xcvr_suspend_q,
  input wire port_a_active_q,
  input wire port_b_active_q,
  input wire host_mode_q,
  input wire port_a_sof_q
);
  // ----
  // write decode, host port wins a clash
  // ----
  wire hw = hpi_sel & hpi_wr & (hpi_addr == CTRL_ADDR);
  wire w = hw | cpu_sel & cpu_wr & (cpu_addr == CTRL_ADDR);
  wire hn = hpi_sel & hpi_wr & (hpi_addr == CNT_ADDR);
  wire n = hn | cpu_sel & cpu_wr & (cpu_addr == CNT_ADDR);
  wire [15:0] wd = hw ? hpi_wdata : cpu_wdata;
  wire [15:0] nd = hn ? hpi_wdata : cpu_wdata;
  wire [3:0] pl = {port_a_dp_pu, port_a_dm_pu, port_a_dp_pd, port_a_dm_pd};
  reg [2:0] quiet_q;
  // invariants wait until outputs have caught up with the last write
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) quiet_q <= 3'h0;
    else if (w | n) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  function [3:0] pulls(input [15:0] d);
    pulls = !d[7] ? 4'h0 : d[9] ? 4'h3 : d[10] ? 4'h4 : 4'h8;
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----
  // assertions
  // ----
  AST_MODE: assert property (w ##1 !w |-> ##1
    host_mode_q == $past(wd[9], 2)) else $error("mode bit");
  AST_SUSP: assert property (w ##1 !w |-> ##1
    xcvr_suspend_q == $past(wd[2], 2)) else $error("suspend bit");
  AST_PULL_A: assert property (w ##1 !w |-> ##1
    pl == pulls($past(wd, 2))) else $error("port a pulls");
  AST_FORCE_A: assert property (w ##1 !w |-> ##1
    port_a_oe == ($past(wd[4:3], 2) != 2'h0)) else $error("force a");
  AST_FORCE_B: assert property (w ##1 !w |-> ##1
    port_b_oe == ($past(wd[6:5], 2) != 2'h0)) else $error("force b");
  AST_PSEL: assert property (n ##1 !n |-> ##1
    port_b_active_q == $past(nd[14], 2) && port_a_active_q != port_b_active_q)
    else $error("port choice");
  AST_SOF_A: assert property (quiet_q == 3'h7 && port_a_sof_q |->
    host_mode_q && port_a_active_q) else $error("marker a");
  AST_SUSP_CAUSE: assert property ($rose(xcvr_suspend_q) |->
    $past(w, 2)) else $error("suspend without write");
endmodule // uplc_asserts

bind uplc_top uplc_asserts #(.CTRL_ADDR(CTRL_ADDR), .CNT_ADDR(CNT_ADDR))
  i_asserts (.*);

/* File: verif/uplc_usb_peer.sv */
// peer on one usb port: dut drive wins, else drives the pair when told, else pulls decide
// assumes levels are {d+, d-} and pulls {dp_pu, dm_pu, dp_pd, dm_pd}
`timescale 1ns/1ps
module uplc_usb_peer (
  input wire core_clk,
  input wire drv_en,
  input wire [1:0] drv,
  input wire oe,
  input wire [1:0] out,
  input wire [3:0] pull,
  output wire [1:0] line
);
  reg [1:0] float_q = 2'h1;
  // an open line wanders, so a stale level never reads back as valid
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end
  assign line[1] = oe ? out[1] : drv_en ? drv[1] :
    pull[3] ? 1'b1 : pull[1] ? 1'b0 : float_q[1];
  assign line[0] = oe ? out[0] : drv_en ? drv[0] :
    pull[2] ? 1'b1 : pull[0] ? 1'b0 : float_q[0];
endmodule // uplc_usb_peer
